// ### design/wdtc_pkg.sv
/*
  Constants, field layout and types of the watchdog timeout block.
  Assumes one reference clock drives the block and its register port.
*/
package wdtc_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [15:0] CFG_ADDR = 16'h0800;
  localparam int PERIOD_MSB = 29;
  localparam int PERIOD_LSB = 28;
  localparam int CLKREF_BIT = 27;
  localparam int PIN2_MSB = 23;
  localparam int PIN2_LSB = 22;
  localparam int KICK_BIT = 18;
  localparam int ACT_MSB = 17;
  localparam int ACT_LSB = 16;
  localparam int PIN1_MSB = 15;
  localparam int PIN1_LSB = 14;
  localparam int WDEN_BIT = 3;

  // ****************************************
  // Reset values and encodings
  // ****************************************
  localparam logic [1:0] PERIOD_RST = 2'h0;
  localparam logic CLKREF_RST = 1'h1;
  localparam logic [1:0] PIN2_RST = 2'h0;
  localparam logic [1:0] ACT_RST = 2'h0;
  localparam logic [1:0] PIN1_RST = 2'h1;
  localparam logic WDEN_RST = 1'h1;
  localparam logic [1:0] ACT_INT = 2'h0;
  localparam logic [1:0] ACT_INH = 2'h1;
  localparam logic [1:0] ACT_PIN = 2'h2;
  localparam logic [1:0] PIN2_NONE = 2'h0;
  localparam logic [1:0] PIN2_CORE = 2'h1;
  localparam logic [1:0] PIN2_WDOG = 2'h2;
  localparam logic [1:0] PIN2_MIRR = 2'h3;
  localparam logic [1:0] PIN1_GPO = 2'h0;
  localparam logic [1:0] PIN1_GPI = 2'h2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int REF_SLOW_HZ = 20_000_000;
  localparam int MS_PER_S = 1000;
  localparam int CYC_PER_MS_SLOW = REF_SLOW_HZ / MS_PER_S;
  localparam logic [12:0] PERIOD0_MS = 13'h003C;
  localparam logic [12:0] PERIOD1_MS = 13'h0258;
  localparam logic [12:0] PERIOD2_MS = 13'h0BB8;
  localparam logic [12:0] PERIOD3_MS = 13'h1770;
  localparam logic [12:0] PULSE_MS = 13'h012C;

  typedef enum logic [2:0] {
    MODE_SLEEP = 3'h1,
    MODE_STANDBY = 3'h2,
    MODE_NORMAL = 3'h4
  } wdtc_mode_e;

  typedef enum logic [1:0] {
    WD_IDLE = 2'h1,
    WD_RUN = 2'h2
  } wdtc_state_e;

  typedef struct packed {
    logic [1:0] period;
    logic clkref;
    logic [1:0] pin2_func;
    logic [1:0] action;
    logic [1:0] pin1_func;
    logic watchdog_enable_bit;
  } wdtc_cfg_s;
endpackage : wdtc_pkg

// ### design/wdtc_top.sv
/*
  Watchdog timeout control: config register, period timer, timeout actions
  and pin functions. Assumes the register port and pins are synchronous to
  i_sys_clk, which is the reference clock.
*/
`timescale 1ns/1ps
// Behaviour
// - Period field picks 60ms, 600ms, 3s, 6s
// - Clock field: 0 is 20MHz, 1 is 40MHz
// - Writing one to kick bit restarts timer
// - Kick bit clears itself after the write
// - Timeout sets kick bit, runs chosen action
// - Action 00: flag, watchdog pin shows low
// - Action 01: inhibit low 300ms, go standby
// - Action 10: pulse watchdog pin low 300ms
// - Every timeout sets the interrupt flag
// - Pin 2 function: none, core, watchdog, mirror
// - Pin 1 function: output or watchdog input
// - Enable bit gates watchdog, default on
// - Timer waits for first trigger after mode entry
// - Watchdog off and silent in sleep
// - Any pin 1 edge restarts the timer while pin 1 is the watchdog input
module wdtc_top #(
  parameter int CYC_PER_MS = wdtc_pkg::CYC_PER_MS_SLOW
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // Register port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  output logic [31:0] o_reg_rdata,
  // Device context
  input wire wdtc_pkg::wdtc_mode_e i_dev_mode,
  input wire logic i_wd_flag_clr,
  input wire logic i_can_core_int_n,
  input wire logic i_interrupt_pin_n,
  input wire logic i_io_pin1_out_level,
  // Pins
  input wire logic i_general_io_pin1,
  output logic o_general_io_pin1,
  output logic o_general_io_pin1_oe_n,
  output logic o_general_out_pin2,
  output logic o_inhibit_output,
  // Status
  output logic o_wd_int_flag,
  output logic o_standby_req,
  output logic o_wd_running
);
  // ****************************************
  // Register file
  // ****************************************
  wdtc_pkg::wdtc_cfg_s cfg_reg;
  logic kick_reg;
  logic cfg_hit;
  logic kick_wr;
  logic timeout;
  logic [31:0] rd_image;

  assign cfg_hit = i_reg_addr == wdtc_pkg::CFG_ADDR;
  assign kick_wr = i_reg_wr && cfg_hit && i_reg_wdata[wdtc_pkg::KICK_BIT];

  // Settings are taken as written; changing them live is the host's hazard
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_reg.period <= wdtc_pkg::PERIOD_RST;
      cfg_reg.clkref <= wdtc_pkg::CLKREF_RST;
      cfg_reg.pin2_func <= wdtc_pkg::PIN2_RST;
      cfg_reg.action <= wdtc_pkg::ACT_RST;
      cfg_reg.pin1_func <= wdtc_pkg::PIN1_RST;
      cfg_reg.watchdog_enable_bit <= wdtc_pkg::WDEN_RST;
    end else if (i_reg_wr && cfg_hit) begin
      cfg_reg.period <= i_reg_wdata[wdtc_pkg::PERIOD_MSB:wdtc_pkg::PERIOD_LSB];
      cfg_reg.clkref <= i_reg_wdata[wdtc_pkg::CLKREF_BIT];
      cfg_reg.pin2_func <= i_reg_wdata[wdtc_pkg::PIN2_MSB:wdtc_pkg::PIN2_LSB];
      cfg_reg.action <= i_reg_wdata[wdtc_pkg::ACT_MSB:wdtc_pkg::ACT_LSB];
      cfg_reg.pin1_func <= i_reg_wdata[wdtc_pkg::PIN1_MSB:wdtc_pkg::PIN1_LSB];
      cfg_reg.watchdog_enable_bit <= i_reg_wdata[wdtc_pkg::WDEN_BIT];
    end
  end

  // Timeout wins over a kick write in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      kick_reg <= 1'h0;
    end else if (timeout) begin
      kick_reg <= 1'h1;
    end else if (kick_wr) begin
      kick_reg <= 1'h0;
    end
  end

  always_comb begin
    rd_image = 32'h0;
    rd_image[wdtc_pkg::PERIOD_MSB:wdtc_pkg::PERIOD_LSB] = cfg_reg.period;
    rd_image[wdtc_pkg::CLKREF_BIT] = cfg_reg.clkref;
    rd_image[wdtc_pkg::PIN2_MSB:wdtc_pkg::PIN2_LSB] = cfg_reg.pin2_func;
    rd_image[wdtc_pkg::KICK_BIT] = kick_reg;
    rd_image[wdtc_pkg::ACT_MSB:wdtc_pkg::ACT_LSB] = cfg_reg.action;
    rd_image[wdtc_pkg::PIN1_MSB:wdtc_pkg::PIN1_LSB] = cfg_reg.pin1_func;
    rd_image[wdtc_pkg::WDEN_BIT] = cfg_reg.watchdog_enable_bit;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_rdata <= 32'h0;
    end else if (i_reg_rd && cfg_hit) begin
      o_reg_rdata <= rd_image;
    end else begin
      o_reg_rdata <= 32'h0;
    end
  end

  // ****************************************
  // Trigger sources and timer state
  // ****************************************
  logic pin1_prev_reg;
  logic pin_edge;
  logic trigger;
  logic wd_active;
  wdtc_pkg::wdtc_mode_e mode_prev_reg;
  wdtc_pkg::wdtc_state_e state_reg;

  assign pin_edge = cfg_reg.pin1_func == wdtc_pkg::PIN1_GPI
                    && (i_general_io_pin1 != pin1_prev_reg);
  assign trigger = kick_wr || pin_edge;
  assign wd_active = cfg_reg.watchdog_enable_bit && i_dev_mode != wdtc_pkg::MODE_SLEEP
                     && i_dev_mode == mode_prev_reg;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin1_prev_reg <= 1'h0;
      mode_prev_reg <= wdtc_pkg::MODE_STANDBY;
    end else begin
      pin1_prev_reg <= i_general_io_pin1;
      mode_prev_reg <= i_dev_mode;
    end
  end

  // Any mode change drops back to waiting for a first trigger
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= wdtc_pkg::WD_IDLE;
    end else begin
      unique case (state_reg)
        wdtc_pkg::WD_IDLE: begin
          if (wd_active && trigger) begin
            state_reg <= wdtc_pkg::WD_RUN;
          end
        end
        wdtc_pkg::WD_RUN: begin
          if (!wd_active) begin
            state_reg <= wdtc_pkg::WD_IDLE;
          end
        end
        default: begin
          state_reg <= wdtc_pkg::WD_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Period counting
  // ****************************************
  localparam int PRE_W = $clog2(2 * CYC_PER_MS + 1);
  logic [PRE_W-1:0] pre_cnt_reg;
  logic [PRE_W-1:0] pre_lim;
  logic [12:0] ms_cnt_reg;
  logic [12:0] period_ms;
  logic tick;
  logic restart;

  // A 40 MHz reference needs twice the cycles per millisecond
  assign pre_lim = cfg_reg.clkref ? PRE_W'(2 * CYC_PER_MS) : PRE_W'(CYC_PER_MS);
  assign tick = pre_cnt_reg == pre_lim - PRE_W'(1);

  always_comb begin
    unique case (cfg_reg.period)
      2'h0: period_ms = wdtc_pkg::PERIOD0_MS;
      2'h1: period_ms = wdtc_pkg::PERIOD1_MS;
      2'h2: period_ms = wdtc_pkg::PERIOD2_MS;
      2'h3: period_ms = wdtc_pkg::PERIOD3_MS;
    endcase
  end

  assign timeout = state_reg == wdtc_pkg::WD_RUN && wd_active && tick
                   && ms_cnt_reg == period_ms - 13'h1;
  assign restart = (wd_active && trigger) || timeout;

  // Prescaler also paces inhibit and pin pulses, so it never stops
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pre_cnt_reg <= '0;
    end else if (restart || tick) begin
      pre_cnt_reg <= '0;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + PRE_W'(1);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ms_cnt_reg <= 13'h0;
    end else if (restart || state_reg != wdtc_pkg::WD_RUN) begin
      ms_cnt_reg <= 13'h0;
    end else if (tick) begin
      ms_cnt_reg <= ms_cnt_reg + 13'h1;
    end
  end

  // ****************************************
  // Timeout actions
  // ****************************************
  logic pulse_on_reg;
  logic pulse_inh_reg;
  logic [12:0] pulse_ms_reg;
  logic pin2_next;

  // Pulse length is within one millisecond of nominal
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pulse_on_reg <= 1'h0;
      pulse_inh_reg <= 1'h0;
      pulse_ms_reg <= 13'h0;
    end else if (timeout && cfg_reg.action == wdtc_pkg::ACT_INH) begin
      pulse_on_reg <= 1'h1;
      pulse_inh_reg <= 1'h1;
      pulse_ms_reg <= 13'h0;
    end else if (timeout && cfg_reg.action == wdtc_pkg::ACT_PIN
                 && cfg_reg.pin2_func == wdtc_pkg::PIN2_WDOG) begin
      pulse_on_reg <= 1'h1;
      pulse_inh_reg <= 1'h0;
      pulse_ms_reg <= 13'h0;
    end else if (pulse_on_reg && tick) begin
      if (pulse_ms_reg == wdtc_pkg::PULSE_MS - 13'h1) begin
        pulse_on_reg <= 1'h0;
      end
      pulse_ms_reg <= pulse_ms_reg + 13'h1;
    end
  end

  // Host clear loses to a timeout in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_wd_int_flag <= 1'h0;
    end else if (timeout) begin
      o_wd_int_flag <= 1'h1;
    end else if (i_wd_flag_clr) begin
      o_wd_int_flag <= 1'h0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_standby_req <= 1'h0;
      o_wd_running <= 1'h0;
    end else begin
      o_standby_req <= timeout && cfg_reg.action == wdtc_pkg::ACT_INH;
      o_wd_running <= state_reg == wdtc_pkg::WD_RUN;
    end
  end

  always_comb begin
    unique case (cfg_reg.pin2_func)
      wdtc_pkg::PIN2_NONE: pin2_next = 1'h1;
      wdtc_pkg::PIN2_CORE: pin2_next = i_can_core_int_n;
      wdtc_pkg::PIN2_WDOG: pin2_next = !((pulse_on_reg && !pulse_inh_reg)
                             || (o_wd_int_flag && cfg_reg.action == wdtc_pkg::ACT_INT));
      wdtc_pkg::PIN2_MIRR: pin2_next = i_interrupt_pin_n;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_inhibit_output <= 1'h1;
      o_general_out_pin2 <= 1'h1;
      o_general_io_pin1 <= 1'h0;
      o_general_io_pin1_oe_n <= 1'h1;
    end else begin
      o_inhibit_output <= !(pulse_on_reg && pulse_inh_reg);
      o_general_out_pin2 <= pin2_next;
      o_general_io_pin1 <= i_io_pin1_out_level;
      o_general_io_pin1_oe_n <= cfg_reg.pin1_func != wdtc_pkg::PIN1_GPO;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  kick_self_clr_a: assert property (kick_wr && !timeout |=> !kick_reg)
    else $error("kick bit not cleared");
  kick_restart_a: assert property (kick_wr && wd_active |=> ms_cnt_reg == 13'h0 && pre_cnt_reg == '0)
    else $error("kick did not restart timer");
  pin_restart_a: assert property (pin_edge && wd_active
                                  |=> state_reg == wdtc_pkg::WD_RUN && ms_cnt_reg == 13'h0)
    else $error("pin edge did not restart timer");
  timeout_mark_a: assert property (timeout |=> kick_reg && o_wd_int_flag)
    else $error("timeout not flagged");
  period_count_a: assert property (timeout |-> ms_cnt_reg == period_ms - 13'h1
                                   && pre_cnt_reg == pre_lim - PRE_W'(1))
    else $error("timeout at wrong count");
  sleep_quiet_a: assert property (i_dev_mode == wdtc_pkg::MODE_SLEEP |-> !timeout)
    else $error("timeout in sleep");
  first_trig_a: assert property (state_reg == wdtc_pkg::WD_IDLE |-> !timeout)
    else $error("timeout before first trigger");
  disable_stop_a: assert property (!cfg_reg.watchdog_enable_bit |=> state_reg == wdtc_pkg::WD_IDLE)
    else $error("watchdog runs while disabled");
  inh_pulse_a: assert property (timeout && cfg_reg.action == wdtc_pkg::ACT_INH
                                |=> o_standby_req ##1 !o_inhibit_output [*2])
    else $error("inhibit pulse missing");
  pin2_pulse_a: assert property (timeout && cfg_reg.action == wdtc_pkg::ACT_PIN
                                 && cfg_reg.pin2_func == wdtc_pkg::PIN2_WDOG
                                 && !i_reg_wr |=> ##1 !o_general_out_pin2)
    else $error("watchdog pin pulse missing");
  pin2_int_a: assert property (o_wd_int_flag && cfg_reg.action == wdtc_pkg::ACT_INT
                               && cfg_reg.pin2_func == wdtc_pkg::PIN2_WDOG && !i_reg_wr
                               |=> !o_general_out_pin2)
    else $error("watchdog pin not low");
  pin2_mirror_a: assert property (cfg_reg.pin2_func == wdtc_pkg::PIN2_MIRR && !i_reg_wr
                                  |=> o_general_out_pin2 == $past(i_interrupt_pin_n))
    else $error("pin 2 mirror wrong");
  pin1_dir_a: assert property (cfg_reg.pin1_func == wdtc_pkg::PIN1_GPI && !i_reg_wr
                               |=> o_general_io_pin1_oe_n)
    else $error("pin 1 driven while input");

  run_cov_c: cover property (state_reg == wdtc_pkg::WD_IDLE ##1 state_reg == wdtc_pkg::WD_RUN);
  tmo_cov_c: cover property (timeout);
  inh_cov_c: cover property (timeout && cfg_reg.action == wdtc_pkg::ACT_INH);
  pin_cov_c: cover property (pin_edge && state_reg == wdtc_pkg::WD_RUN);
endmodule : wdtc_top

// ### dv/wdtc_host_model.sv
/*
  Host-side model: toggles the pin that serves as the watchdog input.
  Assumes it shares the reference clock of the block.
*/
`timescale 1ns/1ps
module wdtc_host_model (
  // Clock
  input wire logic i_sys_clk,
  // Control
  input wire logic i_toggle_en,
  input wire logic [15:0] i_gap,
  // Pin
  output logic o_pin_level
);
  logic [15:0] cnt_reg;

  initial begin
    o_pin_level = 1'b0;
    cnt_reg = 16'h0000;
  end

  // One edge per gap, kept well inside the period
  always @(negedge i_sys_clk) begin
    if (!i_toggle_en) begin
      cnt_reg <= 16'h0000;
    end else if (cnt_reg == i_gap - 16'h0001) begin
      cnt_reg <= 16'h0000;
      o_pin_level <= ~o_pin_level;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end
endmodule : wdtc_host_model

// ### dv/tb_watchdog_timeout_control.sv
/*
  Self-checking bench for the watchdog block: register calls, timeouts,
  pulses and pin functions. Assumes CYC_PER_MS of 4 to keep runs short.
*/
`timescale 1ns/1ps
module tb_watchdog_timeout_control;
  localparam int cpm = 4;
  localparam logic [15:0] cfg_a = wdtc_pkg::CFG_ADDR;
  localparam logic [31:0] kick_m = 32'h0004_0000;
  localparam logic [31:0] en_m = 32'h0000_0008;
  logic i_sys_clk, i_rst_b, i_reg_wr, i_reg_rd, i_wd_flag_clr, i_can_core_int_n, i_interrupt_pin_n;
  logic i_io_pin1_out_level, tog_en, pin1_in, pin1_wire, o_pin1, o_pin1_oe_n, o_pin2, o_inh, o_flag, o_stby, o_run;
  logic [15:0] i_reg_addr;
  logic [31:0] i_reg_wdata, o_reg_rdata, cfg_w, rd_v;
  logic [12:0] per_ms [4];
  wdtc_pkg::wdtc_mode_e i_dev_mode;
  int error_cnt, num_checks, n, exp_cyc;

  // Pin wire: design drives while its enable is low
  assign pin1_wire = o_pin1_oe_n ? pin1_in : o_pin1;

  wdtc_top #(.CYC_PER_MS(cpm)) u_dut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .i_dev_mode(i_dev_mode), .i_wd_flag_clr(i_wd_flag_clr), .i_can_core_int_n(i_can_core_int_n),
    .i_interrupt_pin_n(i_interrupt_pin_n), .i_io_pin1_out_level(i_io_pin1_out_level),
    .i_general_io_pin1(pin1_wire), .o_general_io_pin1(o_pin1), .o_general_io_pin1_oe_n(o_pin1_oe_n),
    .o_general_out_pin2(o_pin2), .o_inhibit_output(o_inh), .o_wd_int_flag(o_flag),
    .o_standby_req(o_stby), .o_wd_running(o_run));

  wdtc_host_model u_host (.i_sys_clk(i_sys_clk), .i_toggle_en(tog_en), .i_gap(16'h0064), .o_pin_level(pin1_in));

  // ********************
  // Tasks
  // ********************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Strobe lowered a cycle before the next call may raise it
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    @(negedge i_sys_clk);
    i_reg_wr = 1'b0;
    @(negedge i_sys_clk);
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    @(negedge i_sys_clk);
    i_reg_rd = 1'b0;
    d = o_reg_rdata;
    @(negedge i_sys_clk);
  endtask : rd

  task automatic wt(input int k);
    repeat (k) @(negedge i_sys_clk);
  endtask : wt

  task automatic clr();
    i_wd_flag_clr = 1'b1;
    @(negedge i_sys_clk);
    i_wd_flag_clr = 1'b0;
    @(negedge i_sys_clk);
  endtask : clr

  // Settings change only with the watchdog disabled
  task automatic setcfg(input logic [31:0] w);
    wr(cfg_a, cfg_w & ~en_m);
    wr(cfg_a, w & ~en_m);
    wr(cfg_a, w);
    cfg_w = w;
  endtask : setcfg

  function automatic logic [31:0] cw(input logic [1:0] per, input logic ck, input logic [1:0] p2,
      input logic [1:0] act, input logic [1:0] p1);
    cw = en_m;
    cw[wdtc_pkg::PERIOD_MSB:wdtc_pkg::PERIOD_LSB] = per;
    cw[wdtc_pkg::CLKREF_BIT] = ck;
    cw[wdtc_pkg::PIN2_MSB:wdtc_pkg::PIN2_LSB] = p2;
    cw[wdtc_pkg::ACT_MSB:wdtc_pkg::ACT_LSB] = act;
    cw[wdtc_pkg::PIN1_MSB:wdtc_pkg::PIN1_LSB] = p1;
  endfunction : cw

  // Cycles from kick until the flag shows
  task automatic tmo(output int k);
    clr();
    wr(cfg_a, cfg_w | kick_m);
    k = 0;
    while (o_flag !== 1'b1 && k < 30000) begin
      @(negedge i_sys_clk);
      k++;
    end
  endtask : tmo

  task automatic pulse(input bit use_pin2, output int len);
    int w;
    w = 0;
    len = 0;
    while (((use_pin2 ? o_pin2 : o_inh) !== 1'b0) && w < 30000) begin
      @(negedge i_sys_clk);
      w++;
    end
    while (((use_pin2 ? o_pin2 : o_inh) === 1'b0) && len < 3000) begin
      @(negedge i_sys_clk);
      len++;
    end
  endtask : pulse

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  // ********************
  // Clock and watchdog
  // ********************
  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end

  initial begin
    #(90000 * 50);
    error_cnt++;
    conclude();
  end

  // ********************
  // Tests
  // ********************
  initial begin
    {i_rst_b, i_reg_wr, i_reg_rd, i_wd_flag_clr, tog_en, i_io_pin1_out_level} = 6'h00;
    {i_can_core_int_n, i_interrupt_pin_n} = 2'h3;
    i_reg_addr = 16'h0000;
    i_reg_wdata = 32'h0000_0000;
    i_dev_mode = wdtc_pkg::MODE_NORMAL;
    per_ms = '{wdtc_pkg::PERIOD0_MS, wdtc_pkg::PERIOD1_MS, wdtc_pkg::PERIOD2_MS, wdtc_pkg::PERIOD3_MS};
    cfg_w = 32'h0800_4008;
    error_cnt = 0;
    num_checks = 0;
    wt(5);
    i_rst_b = 1'b1;
    chk("pins at reset", 32'h31, 32'({o_inh, o_pin2, o_flag, o_run, o_stby, o_pin1_oe_n}));
    rd(cfg_a, rd_v);
    chk("cfg reset", 32'h0800_4008, rd_v);
    rd(16'h0804, rd_v);
    chk("unmapped", 32'h0, rd_v);
    wt(600);
    chk("no start", 32'h0, 32'({o_flag, o_run}));
    $display("test reset done");

    tmo(n);
    chk("period 40MHz", 480, (n >= 477 && n <= 483) ? 480 : n);
    rd(cfg_a, rd_v);
    chk("kick on timeout", kick_m, rd_v & kick_m);
    wr(cfg_a, cfg_w | kick_m);
    rd(cfg_a, rd_v);
    chk("kick self clear", 32'h0, rd_v & kick_m);
    chk("running", 32'h1, 32'(o_run));
    $display("test clock ref done");

    for (int c = 0; c < 4; c++) begin
      setcfg(cw(c[1:0], 1'b0, wdtc_pkg::PIN2_WDOG, wdtc_pkg::ACT_INT, wdtc_pkg::PIN1_RST));
      tmo(n);
      exp_cyc = 32'(per_ms[c]) * cpm;
      chk("period", exp_cyc, (n >= exp_cyc - 3 && n <= exp_cyc + 3) ? exp_cyc : n);
      wt(2);
      chk("pin2 low on flag", 32'h0, 32'(o_pin2));
      clr();
      wt(2);
      chk("pin2 after clear", 32'h1, 32'(o_pin2));
    end
    $display("test periods done");

    setcfg(cw(2'h1, 1'b0, wdtc_pkg::PIN2_NONE, wdtc_pkg::ACT_INH, wdtc_pkg::PIN1_RST));
    tmo(n);
    chk("standby req", 32'h1, 32'(o_stby));
    pulse(1'b0, n);
    chk("inhibit pulse", 1200, (n >= 1196 && n <= 1201) ? 1200 : n);
    setcfg(cw(2'h1, 1'b0, wdtc_pkg::PIN2_WDOG, wdtc_pkg::ACT_PIN, wdtc_pkg::PIN1_RST));
    tmo(n);
    pulse(1'b1, n);
    chk("pin2 pulse", 1200, (n >= 1196 && n <= 1201) ? 1200 : n);
    chk("inhibit idle", 32'h1, 32'(o_inh));
    $display("test actions done");

    for (int k = 0; k < 2; k++) begin
      i_can_core_int_n = k[0];
      i_interrupt_pin_n = ~k[0];
      setcfg(cw(2'h1, 1'b0, wdtc_pkg::PIN2_CORE, wdtc_pkg::ACT_INT, wdtc_pkg::PIN1_RST));
      wt(2);
      chk("pin2 core", 32'(k[0]), 32'(o_pin2));
      setcfg(cw(2'h1, 1'b0, wdtc_pkg::PIN2_MIRR, wdtc_pkg::ACT_INT, wdtc_pkg::PIN1_RST));
      wt(2);
      chk("pin2 mirror", 32'(!k[0]), 32'(o_pin2));
    end
    $display("test pin2 done");

    i_io_pin1_out_level = 1'b1;
    setcfg(cw(2'h0, 1'b0, wdtc_pkg::PIN2_NONE, wdtc_pkg::ACT_INT, wdtc_pkg::PIN1_GPO));
    wt(2);
    chk("pin1 output", 32'h1, 32'({o_pin1_oe_n, o_pin1}));
    setcfg(cw(2'h0, 1'b0, wdtc_pkg::PIN2_NONE, wdtc_pkg::ACT_INT, wdtc_pkg::PIN1_GPI));
    clr();
    tog_en = 1'b1;
    wt(1200);
    chk("pin kicks", 32'h3, 32'({o_flag, o_run, o_pin1_oe_n}));
    tog_en = 1'b0;
    wt(300);
    chk("pin silent", 32'h1, 32'(o_flag));
    $display("test pin1 done");

    setcfg(cw(2'h0, 1'b0, wdtc_pkg::PIN2_NONE, wdtc_pkg::ACT_INT, wdtc_pkg::PIN1_RST));
    clr();
    wr(cfg_a, (cfg_w & ~en_m) | kick_m);
    wt(2);
    chk("disabled", 32'h0, 32'(o_run));
    i_dev_mode = wdtc_pkg::MODE_SLEEP;
    wr(cfg_a, cfg_w | kick_m);
    wt(600);
    chk("sleep", 32'h0, 32'({o_flag, o_run}));
    i_dev_mode = wdtc_pkg::MODE_STANDBY;
    wt(600);
    chk("standby wait", 32'h0, 32'({o_flag, o_run}));
    wr(cfg_a, cfg_w | kick_m);
    wt(2);
    chk("standby run", 32'h1, 32'(o_run));
    $display("test modes done");
    conclude();
  end
endmodule : tb_watchdog_timeout_control
